// ### design/interrupt_mask_ctrl.sv
// Interrupt source mask stage: mask, pending status and trigger mode registers.
// Assumes active-high, clock-synchronous source requests and an AXI4-Lite master.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module interrupt_mask_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [intc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [intc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [intc_pkg::SOURCE_W-1:0] source_req,
  input wire logic emulator_request_pin,
  input wire logic [1:0] ice_breakpoint_req,
  output logic [intc_pkg::SOURCE_W-1:0] core_request,
  output logic irq
);

  // ==========================================================================
  // Decode helpers
  function automatic logic addr_hit(input logic [intc_pkg::ADDR_W-1:0] addr,
                                    input logic [intc_pkg::ADDR_W-1:0] offset);
    addr_hit = (addr[intc_pkg::ADDR_W-1:2] == offset[intc_pkg::ADDR_W-1:2]);
  endfunction : addr_hit

  function automatic logic addr_known(input logic [intc_pkg::ADDR_W-1:0] addr);
    addr_known = addr_hit(addr, intc_pkg::MASK_OFFSET) ||
                 addr_hit(addr, intc_pkg::STATUS_OFFSET) ||
                 addr_hit(addr, intc_pkg::TRIGGER_OFFSET);
  endfunction : addr_known

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    byte_merge = res;
  endfunction : byte_merge

  // ==========================================================================
  // State
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] trigger;
    logic [31:0] edge_pend;
    logic [31:0] src_prev;
    logic [31:0] core_req;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RESET = '{
    mask: intc_pkg::MASK_RESET,
    trigger: intc_pkg::TRIGGER_RESET,
    edge_pend: 32'h0000_0000,
    src_prev: 32'h0000_0000,
    core_req: 32'h0000_0000
  };

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;
  intc_pkg::reg_wr_t reg_wr;
  intc_pkg::reg_rd_t rd_resp;
  logic [intc_pkg::ADDR_W-1:0] rd_addr;
  logic wr_err;
  logic emu_group_req;
  logic [31:0] src_vec;
  logic [31:0] rise;
  logic [31:0] status_cur;
  logic [31:0] clr;
  logic wr_mask;
  logic wr_status;
  logic wr_trigger;

  // ==========================================================================
  // Bus front end
  axil_reg_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .reg_wr(reg_wr),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_resp(rd_resp)
  );

  // ==========================================================================
  // Source gathering
  // Emulator pin and both breakpoints share one status and one mask bit
  assign emu_group_req = emulator_request_pin | (|ice_breakpoint_req);
  assign src_vec = {8'h00, emu_group_req, source_req[intc_pkg::SOURCE_W-2:0]}
                   & intc_pkg::IMPL_BITS;

  // Per-source edge detect and pending selection; level sources show raw input
  for (genvar i = 0; i < 32; i++) begin : g_src
    assign rise[i] = src_vec[i] & ~s_r.src_prev[i];
    assign status_cur[i] = (intc_pkg::EDGE_CAPABLE[i] && s_r.trigger[i]) ?
                           s_r.edge_pend[i] : src_vec[i];
  end

  // Register write decode
  assign wr_mask = reg_wr.en && addr_hit(reg_wr.addr, intc_pkg::MASK_OFFSET);
  assign wr_status = reg_wr.en && addr_hit(reg_wr.addr, intc_pkg::STATUS_OFFSET);
  assign wr_trigger = reg_wr.en && addr_hit(reg_wr.addr, intc_pkg::TRIGGER_OFFSET);
  assign wr_err = !addr_known(reg_wr.addr);

  // Writing one clears only edge-mode bits; level bits follow the requester
  assign clr = wr_status ?
               (byte_merge(32'h0000_0000, reg_wr.data, reg_wr.strb) &
                s_r.trigger & intc_pkg::EDGE_CAPABLE) : 32'h0000_0000;

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.src_prev = src_vec;
    // A new edge in the clear cycle wins, so no event is lost
    s_nxt.edge_pend = ((s_r.edge_pend & ~clr) | rise) & s_r.trigger &
                      intc_pkg::EDGE_CAPABLE;
    // Reserved mask bits are dropped rather than stored
    if (wr_mask) begin
      s_nxt.mask = byte_merge(s_r.mask, reg_wr.data, reg_wr.strb) &
                   intc_pkg::IMPL_BITS;
    end
    if (wr_trigger) begin
      s_nxt.trigger = byte_merge(s_r.trigger, reg_wr.data, reg_wr.strb) &
                      intc_pkg::EDGE_CAPABLE;
    end
    // Uses the new mask so an unmask reaches the core one edge after the write
    s_nxt.core_req = status_cur & ~s_nxt.mask & intc_pkg::IMPL_BITS;
  end

  // Register the whole control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Read mux and outputs
  always_comb begin
    rd_resp.err = 1'b0;
    rd_resp.data = 32'h0000_0000;
    if (addr_hit(rd_addr, intc_pkg::MASK_OFFSET)) begin
      rd_resp.data = s_r.mask;
    end else if (addr_hit(rd_addr, intc_pkg::STATUS_OFFSET)) begin
      rd_resp.data = status_cur;
    end else if (addr_hit(rd_addr, intc_pkg::TRIGGER_OFFSET)) begin
      rd_resp.data = s_r.trigger;
    end else begin
      rd_resp.err = 1'b1;
    end
  end

  assign core_request = s_r.core_req[intc_pkg::SOURCE_W-1:0];
  assign irq = |s_r.core_req;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_masked_quiet;
    (s_r.core_req & s_r.mask) == 32'h0000_0000;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked source reached core");

  property p_status_visible;
    (arvalid && arready && addr_hit(araddr, intc_pkg::STATUS_OFFSET) &&
     s_r.mask[intc_pkg::PERIODIC_RTC_TIMER_MASK_BIT] &&
     src_vec[intc_pkg::PERIODIC_RTC_TIMER_MASK_BIT]) |=>
    rvalid && rdata[intc_pkg::PERIODIC_RTC_TIMER_MASK_BIT];
  endproperty
  a_status_visible: assert property (p_status_visible) else $error("masked status hidden");

  property p_reset_masks;
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (s_r.mask == intc_pkg::MASK_RESET) && !irq;
  endproperty
  a_reset_masks: assert property (p_reset_masks) else $error("mask not all set after reset");

  property p_mask_write;
    (wr_mask && reg_wr.strb == 4'hF) |=>
    (s_r.mask == ($past(reg_wr.data) & intc_pkg::IMPL_BITS));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

  property p_emu_group;
    (ice_breakpoint_req[1] && !s_nxt.mask[intc_pkg::EMULATOR_GROUP_MASK_BIT]) |=>
    core_request[intc_pkg::EMULATOR_GROUP_MASK_BIT] ##0 irq;
  endproperty
  a_emu_group: assert property (p_emu_group) else $error("emulator group request lost");

  property p_request1_path;
    (!s_r.trigger[intc_pkg::EXT_REQUEST1_MASK_BIT] && src_vec[intc_pkg::EXT_REQUEST1_MASK_BIT] &&
     !s_nxt.mask[intc_pkg::EXT_REQUEST1_MASK_BIT]) |=> core_request[intc_pkg::EXT_REQUEST1_MASK_BIT];
  endproperty
  a_request1_path: assert property (p_request1_path) else $error("request1 not forwarded");

  property p_modulator_b_path;
    (src_vec[intc_pkg::MODULATOR_B_MASK_BIT] && s_nxt.mask[intc_pkg::MODULATOR_B_MASK_BIT]) |=>
    !core_request[intc_pkg::MODULATOR_B_MASK_BIT];
  endproperty
  a_modulator_b_path: assert property (p_modulator_b_path) else $error("modulator B leaked");

  property p_line0_edge;
    (s_r.trigger[intc_pkg::EXT_LINE0_MASK_BIT] && rise[intc_pkg::EXT_LINE0_MASK_BIT] &&
     !wr_trigger) |=> s_r.edge_pend[intc_pkg::EXT_LINE0_MASK_BIT] [*1];
  endproperty
  a_line0_edge: assert property (p_line0_edge) else $error("line0 edge not latched");

  property p_watchdog_path;
    $rose(src_vec[intc_pkg::WATCHDOG_MASK_BIT]) && !s_nxt.mask[intc_pkg::WATCHDOG_MASK_BIT] |=>
    core_request[intc_pkg::WATCHDOG_MASK_BIT] && irq;
  endproperty
  a_watchdog_path: assert property (p_watchdog_path) else $error("watchdog not forwarded");

  property p_reserved_zero;
    ((s_r.mask | s_r.core_req) & ~intc_pkg::IMPL_BITS) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_set_wins;
    (rise[intc_pkg::EXT_LINE1_MASK_BIT] && s_r.trigger[intc_pkg::EXT_LINE1_MASK_BIT] &&
     clr[intc_pkg::EXT_LINE1_MASK_BIT]) |=> s_r.edge_pend[intc_pkg::EXT_LINE1_MASK_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("edge lost in clear cycle");

  property p_clear_works;
    (s_r.edge_pend[intc_pkg::EXT_LINE2_MASK_BIT] && clr[intc_pkg::EXT_LINE2_MASK_BIT] &&
     !rise[intc_pkg::EXT_LINE2_MASK_BIT]) |=> !s_r.edge_pend[intc_pkg::EXT_LINE2_MASK_BIT];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("write one did not clear");

  property p_unmask_forward;
    (wr_mask && s_r.mask[intc_pkg::EXT_LINE3_MASK_BIT] &&
     !s_nxt.mask[intc_pkg::EXT_LINE3_MASK_BIT] && status_cur[intc_pkg::EXT_LINE3_MASK_BIT]) |=>
    core_request[intc_pkg::EXT_LINE3_MASK_BIT];
  endproperty
  a_unmask_forward: assert property (p_unmask_forward) else $error("unmask did not forward");

endmodule : interrupt_mask_ctrl

// ### common/intc_pkg.sv
// Constants, field layout and carrier types of the interrupt source mask stage.
// Assumes a 32-bit AXI4-Lite register bus and active-high source request levels.
package intc_pkg;

  // ==========================================================================
  // Register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] TRIGGER_OFFSET = 12'h008;

  // ==========================================================================
  // Field layout and reset values
  localparam logic [31:0] IMPL_BITS = 32'h00FF_3FFF;
  localparam logic [31:0] MASK_RESET = 32'h00FF_3FFF;
  localparam logic [31:0] EDGE_CAPABLE = 32'h000F_0F00;
  localparam logic [31:0] TRIGGER_RESET = 32'h0000_0000;
  localparam int SOURCE_W = 24;

  localparam int EMULATOR_GROUP_MASK_BIT = 23;
  localparam int PERIODIC_RTC_TIMER_MASK_BIT = 22;
  localparam int SERIAL_PERIPH_A_MASK_BIT = 21;
  localparam int EXT_LEVEL5_MASK_BIT = 20;
  localparam int EXT_LEVEL6_MASK_BIT = 19;
  localparam int EXT_REQUEST3_MASK_BIT = 18;
  localparam int EXT_REQUEST2_MASK_BIT = 17;
  localparam int EXT_REQUEST1_MASK_BIT = 16;
  localparam int MODULATOR_B_MASK_BIT = 13;
  localparam int ASYNC_SERIAL_B_MASK_BIT = 12;
  localparam int EXT_LINE3_MASK_BIT = 11;
  localparam int EXT_LINE2_MASK_BIT = 10;
  localparam int EXT_LINE1_MASK_BIT = 9;
  localparam int EXT_LINE0_MASK_BIT = 8;
  localparam int MODULATOR_A_MASK_BIT = 7;
  localparam int KEYPAD_MASK_BIT = 6;
  localparam int TIMER_B_MASK_BIT = 5;
  localparam int TIME_OF_DAY_MASK_BIT = 4;
  localparam int WATCHDOG_MASK_BIT = 3;
  localparam int ASYNC_SERIAL_A_MASK_BIT = 2;
  localparam int TIMER_A_MASK_BIT = 1;
  localparam int SERIAL_PERIPH_B_MASK_BIT = 0;

  // ==========================================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_wr_t;

  typedef struct packed {
    logic [31:0] data;
    logic err;
  } reg_rd_t;

endpackage : intc_pkg

// ### design/axil_reg_port.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
// Assumes the register file answers reads and decode errors combinationally.
`timescale 1ns/1ns
module axil_reg_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [intc_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [intc_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output intc_pkg::reg_wr_t reg_wr,
  input wire logic wr_err,
  output logic [intc_pkg::ADDR_W-1:0] rd_addr,
  input intc_pkg::reg_rd_t rd_resp
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic aw_held;
    logic [intc_pkg::ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } port_state_t;

  port_state_t s_r;
  port_state_t s_nxt;

  // Address and data are parked separately so either may arrive first
  always_comb begin
    s_nxt = s_r;
    reg_wr = '0;
    if (awvalid && !s_r.aw_held) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && !s_r.w_held) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    // Write waits for a pending response to drain, so at most one is open
    if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
      reg_wr.en = 1'b1;
      reg_wr.addr = s_r.aw_addr;
      reg_wr.data = s_r.w_data;
      reg_wr.strb = s_r.w_strb;
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_err ? intc_pkg::RESP_SLVERR : intc_pkg::RESP_OKAY;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // Read data is captured at the address handshake, no extra wait state
    if (arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_resp.data;
      s_nxt.rresp = rd_resp.err ? intc_pkg::RESP_SLVERR : intc_pkg::RESP_OKAY;
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  // Register the whole port state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus outputs
  assign awready = !s_r.aw_held;
  assign wready = !s_r.w_held;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = !s_r.rvalid;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign rd_addr = araddr;

endmodule : axil_reg_port

// ### verif/core_model.sv
// Behavioural model of the processor core that receives the masked requests.
// Assumes the request vector is a set of levels sampled on each rising edge while irq is high.
`timescale 1ns/1ns
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [intc_pkg::SOURCE_W-1:0] core_request,
  input wire logic irq,
  output logic [intc_pkg::SOURCE_W-1:0] taken_r
);
  // ==========================================================================
  // Request capture
  // The core only fetches the vector while the line is raised; a vector
  // without the line would never be seen by a real core either
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taken_r <= '0;
    end else if (irq) begin
      taken_r <= core_request;
    end
  end
endmodule : core_model

// ### verif/tb.sv
// Self-checking bench for the interrupt source mask stage.
// Assumes a single 250 MHz clock and the register offsets of the package.
`timescale 1ns/1ns
module tb;
  logic aclk;
  logic aresetn;
  logic [intc_pkg::ADDR_W-1:0] awaddr;
  logic [intc_pkg::ADDR_W-1:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [intc_pkg::SOURCE_W-1:0] source_req;
  logic [intc_pkg::SOURCE_W-1:0] core_request;
  logic [intc_pkg::SOURCE_W-1:0] taken;
  logic emulator_request_pin;
  logic [1:0] ice_breakpoint_req;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  // ==========================================================================
  // Clock, design and partner
  always #2 aclk = ~aclk;

  interrupt_mask_ctrl uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .source_req(source_req), .emulator_request_pin(emulator_request_pin),
    .ice_breakpoint_req(ice_breakpoint_req), .core_request(core_request), .irq(irq)
  );

  core_model core_partner (
    .aclk(aclk), .aresetn(aresetn), .core_request(core_request), .irq(irq), .taken_r(taken)
  );

  // ==========================================================================
  // Verdict and comparisons
  task automatic test_done;
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk_data(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_data

  task automatic chk_resp(input string name, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_resp

  // Outputs are compared as one zero-extended word so one task serves both
  task automatic chk_out(input logic [31:0] exp_req, input logic exp_irq);
    chk_data("core_request", exp_req, {8'h00, core_request});
    chk_data("irq", {31'h0000_0000, exp_irq}, {31'h0000_0000, irq});
  endtask : chk_out

  // ==========================================================================
  // Bus master tasks
  // Response ready is raised with the request; the slave may answer at once
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : bus_rd

  task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    bus_wr(a, d, r);
    chk_resp("bresp", intc_pkg::RESP_OKAY, r);
  endtask : wr_ok

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(a, d, r);
    chk_resp("rresp", intc_pkg::RESP_OKAY, r);
    chk_data(name, exp, d);
  endtask : rd_chk

  // Settle two edges, then look after the edge updates have landed
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  // ==========================================================================
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] bitv;
    logic [31:0] d;
    logic [1:0] r;
    aclk = 1'b0;
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    source_req = '0;
    emulator_request_pin = 1'b0;
    ice_breakpoint_req = 2'b00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_out(32'h0000_0000, 1'b0);
    rd_chk("mask", intc_pkg::MASK_OFFSET, 32'h00FF_3FFF);
    // Only implemented bits can be set, reserved ones read back zero
    wr_ok(intc_pkg::MASK_OFFSET, 32'hFFFF_FFFF);
    rd_chk("mask", intc_pkg::MASK_OFFSET, 32'h00FF_3FFF);
    // Unmapped place answers with an error and no data
    bus_wr(12'h00C, 32'h0000_0001, r);
    chk_resp("bresp", intc_pkg::RESP_SLVERR, r);
    bus_rd(12'h00C, d, r);
    chk_resp("rresp", intc_pkg::RESP_SLVERR, r);
    chk_data("rdata", 32'h0000_0000, d);
    // Every source asserted but all masked: nothing reaches the core
    source_req <= 24'hFF_FFFF;
    emulator_request_pin <= 1'b1;
    settle();
    chk_out(32'h0000_0000, 1'b0);
    rd_chk("status", intc_pkg::STATUS_OFFSET, 32'h00FF_3FFF);
    // Walk each implemented bit: unmask it alone, then mask it alone; sources never change
    for (int i = 0; i < 24; i++) begin
      if (i == 14 || i == 15) continue;
      bitv = 32'h0000_0001 << i;
      wr_ok(intc_pkg::MASK_OFFSET, 32'h00FF_3FFF & ~bitv);
      chk_out(bitv, 1'b1);
      wr_ok(intc_pkg::MASK_OFFSET, bitv);
      chk_out(32'h00FF_3FFF & ~bitv, 1'b1);
    end
    // Each of the three emulator inputs alone raises the group bit
    source_req <= '0;
    emulator_request_pin <= 1'b0;
    wr_ok(intc_pkg::MASK_OFFSET, 32'h0000_0000);
    settle();
    chk_out(32'h0000_0000, 1'b0);
    for (int j = 0; j < 3; j++) begin
      emulator_request_pin <= (j == 0);
      ice_breakpoint_req <= {j == 2, j == 1};
      settle();
      chk_out(32'h0080_0000, 1'b1);
    end
    chk_data("taken", 32'h0080_0000, {8'h00, taken});
    wr_ok(intc_pkg::MASK_OFFSET, 32'h0080_0000);
    chk_out(32'h0000_0000, 1'b0);
    // Edge mode: a single pulse on three lines posts all three
    ice_breakpoint_req <= 2'b00;
    wr_ok(intc_pkg::TRIGGER_OFFSET, 32'hFFFF_FFFF);
    rd_chk("trigger", intc_pkg::TRIGGER_OFFSET, 32'h000F_0F00);
    @(posedge aclk);
    source_req <= 24'h00_0700;
    @(posedge aclk);
    source_req <= 24'h00_0000;
    settle();
    chk_out(32'h0000_0700, 1'b1);
    rd_chk("status", intc_pkg::STATUS_OFFSET, 32'h0000_0700);
    // Line 1 rises again in the cycle the clear lands, so its new edge must survive
    fork
      wr_ok(intc_pkg::STATUS_OFFSET, 32'h0000_0700);
      begin
        repeat (2) @(posedge aclk);
        source_req <= 24'h00_0200;
      end
    join
    rd_chk("status", intc_pkg::STATUS_OFFSET, 32'h0000_0200);
    source_req <= 24'h00_0000;
    wr_ok(intc_pkg::STATUS_OFFSET, 32'h0000_0200);
    rd_chk("status", intc_pkg::STATUS_OFFSET, 32'h0000_0000);
    settle();
    chk_out(32'h0000_0000, 1'b0);
    // Level mode: a written one cannot clear a source that is still asserted
    wr_ok(intc_pkg::TRIGGER_OFFSET, 32'h0000_0000);
    source_req <= 24'h00_0208;
    wr_ok(intc_pkg::STATUS_OFFSET, 32'h0000_0208);
    rd_chk("status", intc_pkg::STATUS_OFFSET, 32'h0000_0208);
    chk_out(32'h0000_0208, 1'b1);
    // Level sources clear at the requester
    source_req <= 24'h00_0000;
    settle();
    chk_out(32'h0000_0000, 1'b0);
    // A second reset in mid-run restores masks and trigger modes
    wr_ok(intc_pkg::TRIGGER_OFFSET, 32'h0000_0F00);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_out(32'h0000_0000, 1'b0);
    rd_chk("mask", intc_pkg::MASK_OFFSET, 32'h00FF_3FFF);
    rd_chk("trigger", intc_pkg::TRIGGER_OFFSET, 32'h0000_0000);
    test_done();
  end
endmodule : tb
